// >>> pkg/fsp_pkg.sv
// Constants and carrier types for the flash status-poll and identify host
// ---------------------------------------------------------------------------
// Behaviour
// RQ1: Host toggles output enable, chip select or both between status reads.
// RQ2: Host keeps one fixed address for every status read of a poll.
// RQ3: Toggle status is data line 6; its first and last values are undefined.
// RQ4: Identify mode: address bit 0 low gives maker code, high device code.
// RQ5: Device leaves identify mode on power loss and starts in normal mode.
// RQ6: Identify exit sequence returns device to normal array reads.
// RQ7: Host writes command words as data 7..0 and address 14..0.
// RQ8: Lockout enable sequence turns boot block lockout on.
// RQ9: Boot block sits at addresses 0000H to 1FFFH.
// RQ10: In chip erase, output enable high only with write and select low.
// RQ11: Host deems operation done after two equal consecutive status reads.
// ---------------------------------------------------------------------------
package fsp_pkg;
    localparam int FSP_AW = 16;
    localparam int FSP_DW = 8;
    localparam int FSP_CMD_AW = 15;
    localparam int FSP_TOGGLE_BIT = 6;
    localparam int FSP_ID_SEL_BIT = 0;
    localparam logic [15:0] FSP_BOOT_LO = 16'h0000;
    localparam logic [15:0] FSP_BOOT_HI = 16'h1FFF;
    localparam logic [15:0] FSP_ID_MAKER_ADDR = 16'h0000;
    localparam logic [15:0] FSP_ID_DEV_ADDR = 16'h0001;
    // Timing in ns, period 4 ns at 250 MHz
    localparam int FSP_CLK_NS = 4;
    localparam int FSP_ACC_NS = 55;
    localparam int FSP_WP_NS = 90;
    localparam int FSP_WPH_NS = 90;
    localparam int FSP_OEHP_NS = 150;
    localparam int FSP_AH_NS = 50;
    localparam int FSP_ACC_CYC = (FSP_ACC_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
    localparam int FSP_WP_CYC = (FSP_WP_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
    localparam int FSP_WPH_CYC = (FSP_WPH_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
    localparam int FSP_OEHP_CYC = (FSP_OEHP_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
    localparam int FSP_TW = 8;

    // One bus step asked of the pin engine
    typedef struct packed {
        logic write;
        logic [FSP_AW-1:0] addr;
        logic [FSP_DW-1:0] data;
    } fsp_step_t;

    // Host command codes
    typedef enum logic [1:0] {
        FSP_OP_READ,
        FSP_OP_WRITE,
        FSP_OP_POLL
    } fsp_op_t;

    // Address used as command word: only lines 14..0 are meaningful
    function automatic logic [FSP_AW-1:0] fsp_cmd_addr(
        input logic [FSP_AW-1:0] a);
        fsp_cmd_addr = {1'b0, a[FSP_CMD_AW-1:0]};
    endfunction

    function automatic logic fsp_in_boot(input logic [FSP_AW-1:0] a);
        fsp_in_boot = (a >= FSP_BOOT_LO) && (a <= FSP_BOOT_HI);
    endfunction
endpackage

// >>> rtl/fsp_bus_cycle.sv
// Pin engine: one read or write cycle on the parallel flash bus
`timescale 1ns/10ps
`default_nettype none
module fsp_bus_cycle
    import fsp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Step request
    input wire logic start,
    input wire fsp_step_t step,
    output logic busy,
    output logic done,
    output logic [FSP_DW-1:0] rdata,
    // Flash pins
    output logic ce_b,
    output logic oe_b,
    output logic we_b,
    output logic [FSP_AW-1:0] addr,
    output logic [FSP_DW-1:0] dq_o,
    output logic dq_oe,
    input wire logic [FSP_DW-1:0] dq_i
);
    typedef enum {FSP_C_IDLE, FSP_C_ACT, FSP_C_REC} fsp_cyc_t;
    fsp_cyc_t st;
    logic [FSP_TW-1:0] cnt;
    logic is_wr;
    // Three-stage synchroniser on the data pins
    logic [FSP_DW-1:0] s1, s2, s3;

    // ---------------------------------------------------------------
    // Input synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= dq_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Active phase covers access or write pulse; recovery keeps strobes
    // high long enough to form a distinct toggle edge for status reads
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= FSP_C_IDLE;
            cnt <= '0;
            is_wr <= 1'b0;
            ce_b <= 1'b1;
            oe_b <= 1'b1;
            we_b <= 1'b1;
            addr <= '0;
            dq_o <= '0;
            dq_oe <= 1'b0;
            rdata <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (st)
                FSP_C_IDLE: begin
                    if (start) begin
                        is_wr <= step.write;
                        addr <= step.addr;
                        dq_o <= step.data;
                        dq_oe <= step.write;
                        ce_b <= 1'b0;
                        we_b <= !step.write;
                        // Output enable held high while writing: RQ10
                        oe_b <= step.write;
                        cnt <= step.write ? FSP_TW'(FSP_WP_CYC)
                                          : FSP_TW'(FSP_ACC_CYC + 3);
                        st <= FSP_C_ACT;
                    end
                end
                FSP_C_ACT: begin
                    if (cnt != '0) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        // Settled data only after synchroniser agrees
                        if (!is_wr && s2 == s3) begin
                            rdata <= s3;
                        end
                        we_b <= 1'b1;
                        ce_b <= 1'b1;
                        oe_b <= 1'b1; // RQ1
                        cnt <= FSP_TW'(FSP_OEHP_CYC);
                        st <= FSP_C_REC;
                    end
                end
                FSP_C_REC: begin
                    if (cnt != '0) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        dq_oe <= 1'b0;
                        done <= 1'b1;
                        st <= FSP_C_IDLE;
                    end
                end
                default: st <= FSP_C_IDLE;
            endcase
        end
    end

    assign busy = (st != FSP_C_IDLE);

    a_wr_oe_high: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
        !we_b |-> !ce_b && oe_b)
        else $error("output enable low during write pulse");
    a_rec_strobes: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
        $rose(ce_b) |-> ce_b [*8])
        else $error("select high pulse too short");
    a_addr_stable: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
        !ce_b |-> $stable(addr) || $fell(ce_b))
        else $error("address moved during cycle");
    c_write: cover property (@(posedge clk) disable iff (!rst_b)
        $fell(we_b));
endmodule
`default_nettype wire

// >>> rtl/fsp_host.sv
// Host controller: reads, command writes and toggle-bit status polling
`timescale 1ns/10ps
`default_nettype none
module fsp_host
    import fsp_pkg::*;
#(
    parameter int POLL_MAX = 100000
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // User request
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire fsp_op_t REQ_OP,
    input wire logic [FSP_AW-1:0] REQ_ADDR,
    input wire logic [FSP_DW-1:0] REQ_DATA,
    // User answer
    output logic RSP_VALID,
    output logic [FSP_DW-1:0] RSP_DATA,
    output logic RSP_TIMEOUT,
    output logic RSP_BOOT,
    // Flash pins
    output logic CE_B,
    output logic OE_B,
    output logic WE_B,
    output logic [FSP_AW-1:0] ADDR,
    output logic [FSP_DW-1:0] DQ_O,
    output logic DQ_OE,
    input wire logic [FSP_DW-1:0] DQ_I
);
    typedef enum {FSP_H_IDLE, FSP_H_CYC, FSP_H_POLL} fsp_host_st_t;
    fsp_host_st_t st;
    fsp_op_t op;
    fsp_step_t step;
    logic start, busy, done;
    logic [FSP_DW-1:0] rdata;
    logic first, prev_tog;
    logic [31:0] polls;
    logic accept, poll_same, poll_limit;
    // Pin-level watch state for the assertions below
    logic [FSP_AW-1:0] poll_pin_addr;
    logic [FSP_TW-1:0] oe_gap;

    fsp_bus_cycle u_cyc (
        .clk(CLK),
        .rst_b(RST_B),
        .start(start),
        .step(step),
        .busy(busy),
        .done(done),
        .rdata(rdata),
        .ce_b(CE_B),
        .oe_b(OE_B),
        .we_b(WE_B),
        .addr(ADDR),
        .dq_o(DQ_O),
        .dq_oe(DQ_OE),
        .dq_i(DQ_I)
    );

    assign REQ_READY = (st == FSP_H_IDLE) && !busy;
    assign accept = REQ_VALID && REQ_READY;
    // Two equal status reads in a row end a poll; the first read only
    // seeds the comparison, as it may catch the line mid-transition
    assign poll_same = !first
        && (rdata[FSP_TOGGLE_BIT] == prev_tog); // RQ11
    // A status line that never settles must not hang the user
    assign poll_limit = (polls >= 32'(POLL_MAX));

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    // State: a poll stays until two reads agree or the read limit is hit
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st <= FSP_H_IDLE;
        end else begin
            case (st)
                FSP_H_IDLE: begin
                    if (accept) begin
                        st <= (REQ_OP == FSP_OP_POLL) ? FSP_H_POLL
                                                      : FSP_H_CYC;
                    end
                end
                FSP_H_CYC: begin
                    if (done) begin
                        st <= FSP_H_IDLE;
                    end
                end
                FSP_H_POLL: begin
                    if (done && (poll_same || poll_limit)) begin
                        st <= FSP_H_IDLE;
                    end
                end
                default: st <= FSP_H_IDLE;
            endcase
        end
    end

    // Request capture; the step is held untouched for a whole poll
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            op <= FSP_OP_READ;
            step <= '0;
            RSP_BOOT <= 1'b0;
        end else if (accept) begin
            op <= REQ_OP;
            step.write <= (REQ_OP == FSP_OP_WRITE);
            // Command words use address lines 14..0 only
            step.addr <= (REQ_OP == FSP_OP_WRITE)
                ? fsp_cmd_addr(REQ_ADDR) : REQ_ADDR; // RQ7
            step.data <= REQ_DATA;
            RSP_BOOT <= fsp_in_boot(REQ_ADDR); // RQ9
        end
    end

    // Start strobe: once on accept, then after every undecided poll read
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            start <= 1'b0;
        end else begin
            start <= accept || (st == FSP_H_POLL && done
                && !poll_same && !poll_limit); // RQ2
        end
    end

    // Poll bookkeeping: last status bit and number of reads so far
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            first <= 1'b1;
            prev_tog <= 1'b0;
            polls <= '0;
        end else if (accept) begin
            first <= 1'b1;
            polls <= '0;
        end else if (st == FSP_H_POLL && done) begin
            prev_tog <= rdata[FSP_TOGGLE_BIT]; // RQ3
            polls <= polls + 32'h1;
            first <= 1'b0;
        end
    end

    // Answer: one-cycle valid, data and timeout flag stand until the next one
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RSP_VALID <= 1'b0;
            RSP_DATA <= '0;
            RSP_TIMEOUT <= 1'b0;
        end else begin
            RSP_VALID <= 1'b0;
            if (st == FSP_H_CYC && done) begin
                RSP_DATA <= rdata;
                RSP_TIMEOUT <= 1'b0;
                RSP_VALID <= 1'b1;
            end else if (st == FSP_H_POLL && done
                && (poll_same || poll_limit)) begin
                RSP_DATA <= rdata; // RQ11
                RSP_TIMEOUT <= !poll_same;
                RSP_VALID <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Pin-level watch
    // ---------------------------------------------------------------
    // Poll address taken from the request itself, not from the step path
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            poll_pin_addr <= '0;
        end else if (accept) begin
            poll_pin_addr <= REQ_ADDR;
        end
    end

    // Strobe-high cycles, saturating, so a long idle counts as long
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            oe_gap <= '1;
        end else if (!OE_B) begin
            oe_gap <= '0;
        end else if (oe_gap != '1) begin
            oe_gap <= oe_gap + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Assertions and covers
    // ---------------------------------------------------------------
    a_poll_addr: assert property (@(posedge CLK) disable iff (!RST_B) // RQ2
        st == FSP_H_POLL && start && !first |-> $stable(step.addr))
        else $error("poll address changed");
    a_poll_pins: assert property (@(posedge CLK) disable iff (!RST_B) // RQ2
        st == FSP_H_POLL && !CE_B |-> ADDR == poll_pin_addr)
        else $error("poll read on another address");
    a_poll_finish: assert property (@(posedge CLK) disable iff (!RST_B) // RQ11
        st == FSP_H_POLL && done && !first
        && rdata[FSP_TOGGLE_BIT] == prev_tog |=> RSP_VALID)
        else $error("poll did not finish on equal reads");
    a_poll_first: assert property (@(posedge CLK) disable iff (!RST_B) // RQ3
        st == FSP_H_POLL && done && first && POLL_MAX > 0
        |=> !RSP_VALID)
        else $error("poll ended on first read");
    a_cmd_addr: assert property (@(posedge CLK) disable iff (!RST_B) // RQ7
        !WE_B |-> ADDR[FSP_AW-1] == 1'b0)
        else $error("command address above line 14");
    a_erase_oe: assert property (@(posedge CLK) disable iff (!RST_B) // RQ10
        !WE_B |-> OE_B && !CE_B)
        else $error("output enable not high while writing");
    a_toggle_edge: assert property (@(posedge CLK) disable iff (!RST_B) // RQ1
        st == FSP_H_POLL && $fell(OE_B)
        |-> oe_gap >= FSP_TW'(FSP_OEHP_CYC))
        else $error("strobe high pulse too short between status reads");
    a_boot_flag: assert property (@(posedge CLK) disable iff (!RST_B) // RQ9
        accept && REQ_ADDR <= FSP_BOOT_HI |=> RSP_BOOT)
        else $error("boot block flag missing");
    a_boot_clear: assert property (@(posedge CLK) disable iff (!RST_B) // RQ9
        accept && REQ_ADDR > FSP_BOOT_HI |=> !RSP_BOOT)
        else $error("boot block flag set outside the block");
    a_rsp_pulse: assert property (@(posedge CLK) disable iff (!RST_B)
        RSP_VALID |=> !RSP_VALID)
        else $error("answer longer than one cycle");
    c_poll_done: cover property (@(posedge CLK) disable iff (!RST_B)
        st == FSP_H_POLL ##1 RSP_VALID && !RSP_TIMEOUT);
    c_read: cover property (@(posedge CLK) disable iff (!RST_B)
        st == FSP_H_CYC && done && op == FSP_OP_READ);
    c_timeout: cover property (@(posedge CLK) disable iff (!RST_B)
        RSP_VALID && RSP_TIMEOUT);
endmodule
`default_nettype wire

// >>> verification/fsp_flash_model.sv
// Behavioural model of the parallel flash that the host controller drives
`timescale 1ns/10ps
`default_nettype none
module fsp_flash_model
    import fsp_pkg::*;
#(
    parameter logic [15:0] U1A = 16'h5555,
    parameter logic [15:0] U2A = 16'h2AAA,
    parameter logic [7:0] U1D = 8'hAA,
    parameter logic [7:0] U2D = 8'h55,
    parameter logic [7:0] C_ID = 8'h90,
    parameter logic [7:0] C_EXIT = 8'hF0,
    parameter logic [7:0] C_PROG = 8'hA0,
    parameter logic [7:0] C_LOCK = 8'h40,
    parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value
    parameter logic [7:0] DEVICE = 8'hC3 // Arbitrary value
)
(
    // Strobes, power and program time
    input wire logic ce_b,
    input wire logic oe_b,
    input wire logic we_b,
    input wire logic pwr_ok,
    input var int op_ns,
    // Address and data
    input wire logic [FSP_AW-1:0] addr,
    input wire logic [FSP_DW-1:0] dq_in,
    output logic [FSP_DW-1:0] dq_out
);
    logic [7:0] mem [0:65535];
    logic [15:0] la;
    logic [7:0] ld, val, held = 8'h00;
    logic id_mode = 0, locked = 0, armed = 0, busy = 0, tog = 0;
    logic [1:0] stg = 2'h0;
    logic rd_on;

    // Array starts with a pattern that differs in both address bytes
    initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8];

    // Status while busy, codes in identify mode, array otherwise
    always_comb begin
        if (busy) val = {1'b0, tog, 6'h00};
        else if (id_mode) val = addr[0] ? DEVICE : MAKER;
        else val = mem[addr];
    end

    // A released bus shows the inverse of the last byte, never a stale match
    always @(*) if (!ce_b && !oe_b && we_b) held = val;
    assign dq_out = (!ce_b && !oe_b && we_b) ? val : ~held;

    // Each new read while busy flips the status line; one combined enable
    // so strobes falling together flip it only once
    assign rd_on = !ce_b && !oe_b && we_b;
    always @(posedge rd_on) if (busy) tog <= ~tog;

    // Latch the write while the strobe is low, act on its rising edge
    always @(*) if (!we_b && !ce_b) begin
        la = addr;
        ld = dq_in;
    end
    always @(posedge we_b or negedge pwr_ok) begin
        if (!pwr_ok) begin
            id_mode <= 0;
            stg <= 0;
            armed <= 0;
        end else if (armed) begin
            armed <= 0;
            stg <= 0;
            if (!(locked && la <= FSP_BOOT_HI)) begin
                mem[la] <= ld;
                busy <= 1;
                busy <= #(op_ns) 0;
            end
        end else if (stg == 0 && la == U1A && ld == U1D) stg <= 1;
        else if (stg == 1 && la == U2A && ld == U2D) stg <= 2;
        else begin
            stg <= 0;
            if (stg == 2 && la == U1A) begin
                if (ld == C_ID) id_mode <= 1;
                if (ld == C_EXIT) id_mode <= 0;
                if (ld == C_PROG) armed <= 1;
                if (ld == C_LOCK) locked <= 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/fsp_host_test.sv
// Self-checking testbench of the flash host controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("wrong value %s exp %h got %h", what, exp, got); \
    end \
end
module fsp_host_test
    import fsp_pkg::*;
;
    logic CLK = 0, RST_B = 0, REQ_VALID = 0, pwr_ok = 1, poll_on = 0;
    fsp_op_t REQ_OP = FSP_OP_READ;
    logic [15:0] REQ_ADDR = 16'h0000, ADDR, poll_addr;
    logic [7:0] REQ_DATA = 8'h00, RSP_DATA, DQ_O, DQ_I, flash_dq;
    logic REQ_READY, RSP_VALID, RSP_TIMEOUT, RSP_BOOT;
    logic CE_B, OE_B, WE_B, DQ_OE;
    int bad_count = 0, samples_checked = 0, op_ns = 200, poll_reads = 0;

    fsp_host #(.POLL_MAX(4)) DUT (.CLK(CLK), .RST_B(RST_B),
        .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ_OP(REQ_OP),
        .REQ_ADDR(REQ_ADDR), .REQ_DATA(REQ_DATA), .RSP_VALID(RSP_VALID),
        .RSP_DATA(RSP_DATA), .RSP_TIMEOUT(RSP_TIMEOUT),
        .RSP_BOOT(RSP_BOOT), .CE_B(CE_B), .OE_B(OE_B), .WE_B(WE_B),
        .ADDR(ADDR), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .DQ_I(DQ_I));
    fsp_flash_model flash (.ce_b(CE_B), .oe_b(OE_B), .we_b(WE_B),
        .pwr_ok(pwr_ok), .op_ns(op_ns), .addr(ADDR), .dq_in(DQ_I),
        .dq_out(flash_dq));
    // Bus level: the host wins while it drives
    assign DQ_I = DQ_OE ? DQ_O : flash_dq;

    initial forever #2 CLK = ~CLK;

    // ----------------------------------------
    // Pin monitors
    // ----------------------------------------
    // Look a little after the edge so every strobe and address has settled
    always @(negedge WE_B) begin
        #1;
        `CHK("oe_b in write", 1'b1, OE_B)
        `CHK("addr bit 15", 1'b0, ADDR[15])
    end
    always @(negedge OE_B) if (poll_on) begin
        #1;
        `CHK("poll address", poll_addr, ADDR)
        poll_reads++;
    end

    // ----------------------------------------
    // Request tasks
    // ----------------------------------------
    task automatic req(input fsp_op_t op, input logic [15:0] a,
            input logic [7:0] d);
        int n;
        @(posedge CLK);
        #1;
        REQ_OP = op;
        REQ_ADDR = a;
        REQ_DATA = d;
        REQ_VALID = 1;
        @(posedge CLK);
        #1;
        REQ_VALID = 0;
        `CHK("busy refuses", 1'b0, REQ_READY)
        for (n = 0; n < 2000 && RSP_VALID !== 1'b1; n++) begin
            @(posedge CLK);
            #1;
        end
        `CHK("answer", 1'b1, RSP_VALID)
    endtask
    // Bit 15 set on the last word: the host must clear it on the pins
    task automatic cmd(input logic [7:0] c);
        req(FSP_OP_WRITE, 16'h5555, 8'hAA);
        req(FSP_OP_WRITE, 16'h2AAA, 8'h55);
        req(FSP_OP_WRITE, 16'hD555, c);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        req(FSP_OP_READ, a, 8'h00);
        `CHK("read data", exp, RSP_DATA)
    endtask
    task automatic poll(input logic [15:0] a);
        poll_reads = 0;
        poll_addr = a;
        poll_on = 1;
        req(FSP_OP_POLL, a, 8'h00);
        poll_on = 0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_array;
        `CHK("idle pins", 5'b11101, {CE_B, OE_B, WE_B, DQ_OE, REQ_READY})
        rd(16'h1FFF, 8'hE0);
        `CHK("boot flag", 1'b1, RSP_BOOT)
        rd(16'h2000, 8'h20);
        `CHK("boot flag", 1'b0, RSP_BOOT)
    endtask
    task automatic t_ident;
        cmd(8'h90);
        rd(16'h0000, 8'h5A);
        rd(16'h0001, 8'hC3);
        cmd(8'hF0);
        rd(16'h0001, 8'h01);
        cmd(8'h90);
        pwr_ok = 0;
        #20 pwr_ok = 1;
        rd(16'h0001, 8'h01);
    endtask
    task automatic t_lock;
        cmd(8'h40);
        cmd(8'hA0);
        req(FSP_OP_WRITE, 16'h1FFF, 8'h00);
        rd(16'h1FFF, 8'hE0);
    endtask
    task automatic t_poll;
        cmd(8'hA0);
        req(FSP_OP_WRITE, 16'h2000, 8'h42);
        poll(16'h2000);
        `CHK("poll timeout", 1'b0, RSP_TIMEOUT)
        `CHK("poll data", 8'h42, RSP_DATA)
        `CHK("poll reads", 1'b1, poll_reads >= 2)
    endtask
    // A long operation keeps the status line moving past the read limit
    task automatic t_poll_slow;
        op_ns = 40000;
        cmd(8'hA0);
        req(FSP_OP_WRITE, 16'h2001, 8'h5A);
        poll(16'h2001);
        `CHK("slow timeout", 1'b1, RSP_TIMEOUT)
        repeat (10000) @(posedge CLK);
        poll(16'h2001);
        `CHK("late data", 8'h5A, RSP_DATA)
        `CHK("late timeout", 1'b0, RSP_TIMEOUT)
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge CLK);
        #1;
        RST_B = 1;
        t_array();
        t_ident();
        t_lock();
        t_poll();
        t_poll_slow();
        results();
    end
    // Whole run needs about 13000 cycles
    initial begin
        repeat (40000) @(posedge CLK);
        bad_count++;
        results();
    end
endmodule
`default_nettype wire
